// [verilog/risr2_defines.svh]
// offsets, masks, reset values and timing counts of the second status block
`ifndef RISR2_DEFINES_SVH
`define RISR2_DEFINES_SVH

`define RISR2_OFF_STATUS_ONE   8'h03
`define RISR2_OFF_STATUS_TWO   8'h04
`define RISR2_OFF_ENABLE_ONE   8'h05
`define RISR2_OFF_ENABLE_TWO   8'h06

`define RISR2_BIT_SYNC         7
`define RISR2_BIT_PRE_GOOD     6
`define RISR2_BIT_PRE_MISS     5
`define RISR2_BIT_SIG_LVL      4
`define RISR2_BIT_WAKEUP       3
`define RISR2_BIT_BATT_LOW     2
`define RISR2_BIT_OSC_OK       1
`define RISR2_BIT_POWER_UP     0

// flags that stay pending while their latched level stays high
`define RISR2_LATCH_MASK       8'h04
`define RISR2_ENABLE_RST       8'h00
`define RISR2_STATUS_RST       8'h00

`define RISR2_CLK_PERIOD_NS    100
`define RISR2_OSC_SETTLE_NS    1000
`define RISR2_OSC_SETTLE_CYC   ((`RISR2_OSC_SETTLE_NS + `RISR2_CLK_PERIOD_NS - 1) / `RISR2_CLK_PERIOD_NS)

`endif

// [verilog/risr2_pkg.sv]
// types of the second status block
package risr2_pkg;

	typedef enum logic [1:0] {
		RISR2_OSC_IDLE   = 2'h0,
		RISR2_OSC_SETTLE = 2'h1,
		RISR2_OSC_READY  = 2'h3
	} risr2_osc_t;

	typedef struct packed {
		logic [7:0]  en_one;     // enable mask of first status
		logic [7:0]  en_two;     // enable mask of second status
		logic [7:0]  pend_one;   // latched events of first status
		logic [7:0]  pend_two;   // latched events of second status
		logic [7:0]  prev_one;   // sampled first status, one cycle old
		logic [7:0]  prev_two;   // live second status, one cycle old
		logic [7:0]  live_one;   // sampled first status
		logic        sync;       // sync word seen, packet running
		logic        pre;        // preamble seen, waiting for sync
		logic        miss;       // preamble miss, one cycle
		logic        rssi;       // signal above threshold
		logic        wut;        // wake-up expiry, one cycle
		logic        lbd;        // battery low, held
		logic        por;        // power-up seen, held
		risr2_osc_t  osc;        // oscillator settling state
		logic [15:0] osc_cnt;    // settling counter
		logic [7:0]  rdata;      // read answer
		logic        alert_n;    // interrupt line
	} risr2_state_t;

endpackage : risr2_pkg

// [verilog/risr2.sv]
// second interrupt/status register, enables and shared host interrupt line
// Operation
// RULE1 - status two read at 04h, sync..power-up from bit 7 to 0
// RULE2 - status content undefined after reset; host must not rely on it
// RULE3 - sync flag rises on sync word, falls when packet is done
// RULE4 - preamble flag rises on preamble, falls on sync or sync timeout
// RULE5 - preamble miss flag set on receiver timeout, clears by itself
// RULE6 - signal level flag high while strength stays above threshold
// RULE7 - wake-up flag set when wake-up timer expires
// RULE8 - battery low latched even when disabled; interrupts once enabled
// RULE9 - oscillator flag high after settling time, low back in idle
// RULE10 - power-up flag set on power-on detection
// RULE11 - enabled flag rising pulls host_alert_n low
// RULE12 - reading status two releases alert and clears enabled flags
// RULE13 - disabled flags are live status, untouched by reads
// RULE14 - host should treat wake-up and preamble miss as interrupts
// RULE15 - enable bits for status two live at 06h, same positions
// RULE16 - first status register shares host_alert_n with its own enables
// RULE17 - alert stays low while any enabled flag in either register pends
`timescale 1ns/1ps
`include "risr2_defines.svh"
`default_nettype none

module risr2_status #(
	parameter int OSC_SETTLE_CYC = `RISR2_OSC_SETTLE_CYC
) (
	input  wire logic       mclk,               // system clock, 10 MHz
	input  wire logic       rst_n,              // synchronous reset, low
	input  wire logic [7:0] reg_addr,           // register offset
	input  wire logic [7:0] reg_wdata,          // write data
	input  wire logic       reg_wr,             // write strobe
	input  wire logic       reg_rd,             // read strobe
	output logic      [7:0] reg_rdata,          // read data, cycle after read
	input  wire logic       sync_found_evt,     // sync word detected
	input  wire logic       packet_done_evt,    // packet reception over
	input  wire logic       preamble_found_evt, // preamble detected
	input  wire logic       sync_timeout_evt,   // wait for sync expired
	input  wire logic       preamble_miss_evt,  // no preamble after rx on
	input  wire logic       signal_above_lvl,   // strength above threshold
	input  wire logic       wakeup_expiry_evt,  // wake-up timer expired
	input  wire logic       battery_low_evt,    // low battery detected
	input  wire logic       osc_request,        // xtal, tx or rx enabled
	input  wire logic       power_up_evt,       // power-on detected
	input  wire logic [7:0] status_one_live,    // first status live levels
	output logic            host_alert_n        // interrupt to host, low
);

	risr2_pkg::risr2_state_t q;
	risr2_pkg::risr2_state_t next_q;

	logic [7:0] raw_two;
	logic [7:0] rise_one;
	logic [7:0] rise_two;
	logic [7:0] set_one;
	logic [7:0] set_two;
	logic [7:0] clr_one;
	logic [7:0] clr_two;
	logic [7:0] view_one;
	logic [7:0] view_two;
	logic       rd_one;
	logic       rd_two;

	// live flags of status two, ordered as read by the host
	// RULE1 flag bit order
	assign raw_two = {q.sync, q.pre, q.miss, q.rssi, q.wut, q.lbd,
		q.osc == risr2_pkg::RISR2_OSC_READY, q.por};

	// reads of either status register
	assign rd_one = reg_rd && (reg_addr == `RISR2_OFF_STATUS_ONE);
	assign rd_two = reg_rd && (reg_addr == `RISR2_OFF_STATUS_TWO);

	// rising edges, set and read-clear terms
	// RULE11 rise detection
	assign rise_one = q.live_one & ~q.prev_one;
	assign rise_two = raw_two & ~q.prev_two;
	// RULE12 clear enabled on read
	assign clr_one  = rd_one ? q.en_one : 8'h00;
	assign clr_two  = rd_two ? q.en_two : 8'h00;
	assign set_one  = rise_one & q.en_one;
	// RULE8 latched event re-arms
	assign set_two  = (rise_two | (raw_two & `RISR2_LATCH_MASK & ~clr_two)) & q.en_two;

	// what the host sees: pending where enabled, live where not
	// RULE13 disabled bits live
	assign view_one = (q.pend_one & q.en_one) | (q.live_one & ~q.en_one);
	assign view_two = (q.pend_two & q.en_two) | (raw_two & ~q.en_two);

	// next state of the whole block
	always_comb begin
		next_q          = q;
		next_q.live_one = status_one_live;
		next_q.prev_one = q.live_one;
		next_q.prev_two = raw_two;
		// RULE6 live signal level
		next_q.rssi     = signal_above_lvl;
		// RULE3 sync flag
		if (sync_found_evt) begin
			next_q.sync = 1'b1;
		end else if (packet_done_evt) begin
			next_q.sync = 1'b0;
		end
		// RULE4 preamble flag
		if (preamble_found_evt) begin
			next_q.pre = 1'b1;
		end else if (sync_found_evt || sync_timeout_evt) begin
			next_q.pre = 1'b0;
		end
		// RULE5 self clearing miss
		next_q.miss = preamble_miss_evt;
		// RULE7 wake-up expiry
		next_q.wut  = wakeup_expiry_evt;
		// RULE8 battery low latch
		if (battery_low_evt) begin
			next_q.lbd = 1'b1;
		end else if (clr_two[`RISR2_BIT_BATT_LOW]) begin
			next_q.lbd = 1'b0;
		end
		// RULE10 power-up latch
		if (power_up_evt) begin
			next_q.por = 1'b1;
		end else if (clr_two[`RISR2_BIT_POWER_UP]) begin
			next_q.por = 1'b0;
		end
		// RULE9 oscillator settling
		case (q.osc)
			risr2_pkg::RISR2_OSC_IDLE: begin
				next_q.osc_cnt = 16'h0000;
				if (osc_request) begin
					next_q.osc = risr2_pkg::RISR2_OSC_SETTLE;
				end
			end
			risr2_pkg::RISR2_OSC_SETTLE: begin
				if (!osc_request) begin
					next_q.osc = risr2_pkg::RISR2_OSC_IDLE;
				end else if (q.osc_cnt >= 16'(OSC_SETTLE_CYC - 1)) begin
					next_q.osc = risr2_pkg::RISR2_OSC_READY;
				end else begin
					next_q.osc_cnt = q.osc_cnt + 16'h0001;
				end
			end
			risr2_pkg::RISR2_OSC_READY: begin
				if (!osc_request) begin
					next_q.osc = risr2_pkg::RISR2_OSC_IDLE;
				end
			end
			default: begin
				next_q.osc = risr2_pkg::RISR2_OSC_IDLE;
			end
		endcase
		// RULE16 first register pending
		next_q.pend_one = (q.pend_one & ~clr_one) | set_one;
		// RULE11 set wins over read
		next_q.pend_two = (q.pend_two & ~clr_two) | set_two;
		// RULE15 enable registers
		if (reg_wr && reg_addr == `RISR2_OFF_ENABLE_ONE) begin
			next_q.en_one = reg_wdata;
		end
		if (reg_wr && reg_addr == `RISR2_OFF_ENABLE_TWO) begin
			next_q.en_two = reg_wdata;
		end
		// read answer, zero when unmapped or idle
		next_q.rdata = 8'h00;
		if (reg_rd) begin
			case (reg_addr)
				`RISR2_OFF_STATUS_ONE: next_q.rdata = view_one;
				`RISR2_OFF_STATUS_TWO: next_q.rdata = view_two;
				`RISR2_OFF_ENABLE_ONE: next_q.rdata = q.en_one;
				`RISR2_OFF_ENABLE_TWO: next_q.rdata = q.en_two;
				default:               next_q.rdata = 8'h00;
			endcase
		end
		// RULE17 alert while anything pends
		next_q.alert_n = ~|((next_q.pend_one & next_q.en_one) |
			(next_q.pend_two & next_q.en_two));
	end

	// state register
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			q         <= '0;
			q.en_one  <= `RISR2_ENABLE_RST;
			q.en_two  <= `RISR2_ENABLE_RST;
			// RULE2 status reset chosen
			q.pend_two <= `RISR2_STATUS_RST;
			q.osc     <= risr2_pkg::RISR2_OSC_IDLE;
			q.alert_n <= 1'b1;
		end else begin
			q <= next_q;
		end
	end

	assign reg_rdata    = q.rdata;
	assign host_alert_n = q.alert_n;

	// checks on the block's own behaviour
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	property p_read_view;
		rd_two |=> reg_rdata == $past(view_two);
	endproperty
	a_read_view: assert property (p_read_view) // RULE1
		else $error("status two read data wrong");

	property p_sync_set;
		sync_found_evt |=> q.sync ##1 (raw_two[`RISR2_BIT_SYNC] || $past(packet_done_evt));
	endproperty
	a_sync_set: assert property (p_sync_set) // RULE3
		else $error("sync flag did not rise");

	property p_sync_clr;
		packet_done_evt && !sync_found_evt |=> !raw_two[`RISR2_BIT_SYNC];
	endproperty
	a_sync_clr: assert property (p_sync_clr) // RULE3
		else $error("sync flag did not fall");

	property p_pre_clr;
		(sync_found_evt || sync_timeout_evt) && !preamble_found_evt |=> !q.pre;
	endproperty
	a_pre_clr: assert property (p_pre_clr) // RULE4
		else $error("preamble flag did not fall");

	property p_miss_self;
		preamble_miss_evt ##1 !preamble_miss_evt |=> !raw_two[`RISR2_BIT_PRE_MISS];
	endproperty
	a_miss_self: assert property (p_miss_self) // RULE5
		else $error("preamble miss did not clear");

	property p_rssi_level;
		signal_above_lvl[*2] |-> raw_two[`RISR2_BIT_SIG_LVL];
	endproperty
	a_rssi_level: assert property (p_rssi_level) // RULE6
		else $error("signal level flag low while above");

	property p_wut_pend;
		wakeup_expiry_evt && q.en_two[`RISR2_BIT_WAKEUP] && !reg_wr
			|=> ##1 q.pend_two[`RISR2_BIT_WAKEUP];
	endproperty
	a_wut_pend: assert property (p_wut_pend) // RULE7
		else $error("wake-up expiry not latched");

	property p_lbd_kept;
		q.lbd && !q.en_two[`RISR2_BIT_BATT_LOW] |=> q.lbd;
	endproperty
	a_lbd_kept: assert property (p_lbd_kept) // RULE8
		else $error("disabled battery flag lost");

	property p_osc_idle;
		!osc_request |=> q.osc == risr2_pkg::RISR2_OSC_IDLE;
	endproperty
	a_osc_idle: assert property (p_osc_idle) // RULE9
		else $error("oscillator flag stayed up in idle");

	property p_osc_rise;
		$rose(q.osc == risr2_pkg::RISR2_OSC_READY) |->
			$past(q.osc) == risr2_pkg::RISR2_OSC_SETTLE;
	endproperty
	a_osc_rise: assert property (p_osc_rise) // RULE9
		else $error("oscillator ready without settling");

	property p_por_set;
		power_up_evt |=> q.por;
	endproperty
	a_por_set: assert property (p_por_set) // RULE10
		else $error("power-up flag not set");

	property p_alert_low;
		(|set_two) && !reg_wr |=> !host_alert_n;
	endproperty
	a_alert_low: assert property (p_alert_low) // RULE11
		else $error("enabled rise did not pull alert low");

	property p_read_clear;
		rd_two && set_two == 8'h00 && !reg_wr |=> (q.pend_two & q.en_two) == 8'h00;
	endproperty
	a_read_clear: assert property (p_read_clear) // RULE12
		else $error("read left enabled flags pending");

	property p_enable_write;
		reg_wr && reg_addr == `RISR2_OFF_ENABLE_TWO |=> q.en_two == $past(reg_wdata);
	endproperty
	a_enable_write: assert property (p_enable_write) // RULE15
		else $error("enable two not written");

	property p_one_alert;
		(|set_one) && !reg_wr |=> !host_alert_n;
	endproperty
	a_one_alert: assert property (p_one_alert) // RULE16
		else $error("first status rise did not alert");

	property p_alert_hold;
		|((q.pend_one & q.en_one) | (q.pend_two & q.en_two)) |-> !host_alert_n;
	endproperty
	a_alert_hold: assert property (p_alert_hold) // RULE17
		else $error("alert high with pending flag");

	property p_pre_set;
		preamble_found_evt |=> q.pre;
	endproperty
	a_pre_set: assert property (p_pre_set) // RULE4
		else $error("preamble flag did not rise");

	property p_miss_set;
		preamble_miss_evt |=> raw_two[`RISR2_BIT_PRE_MISS];
	endproperty
	a_miss_set: assert property (p_miss_set) // RULE5
		else $error("preamble miss flag not set");

	property p_rssi_low;
		!signal_above_lvl |=> !raw_two[`RISR2_BIT_SIG_LVL];
	endproperty
	a_rssi_low: assert property (p_rssi_low) // RULE6
		else $error("signal level flag high while below");

	property p_wut_self;
		!wakeup_expiry_evt |=> !raw_two[`RISR2_BIT_WAKEUP];
	endproperty
	a_wut_self: assert property (p_wut_self) // RULE7
		else $error("wake-up flag not momentary");

	property p_lbd_set;
		battery_low_evt |=> raw_two[`RISR2_BIT_BATT_LOW];
	endproperty
	a_lbd_set: assert property (p_lbd_set) // RULE8
		else $error("battery low flag not set");

	property p_live_kept;
		rd_two && q.lbd && !q.en_two[`RISR2_BIT_BATT_LOW] |=> q.lbd;
	endproperty
	a_live_kept: assert property (p_live_kept) // RULE13
		else $error("read changed a disabled flag");

	property p_rdata_idle;
		!reg_rd |=> reg_rdata == 8'h00;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) // RULE1
		else $error("read data outside read answer");

	property p_alert_release;
		rd_two && !(|set_two) && !(|set_one) && (q.pend_one & q.en_one) == 8'h00
			|=> host_alert_n;
	endproperty
	a_alert_release: assert property (p_alert_release) // RULE12
		else $error("read did not release alert");

	c_alert_read: cover property (!host_alert_n ##1 rd_two ##1 host_alert_n);
	c_sync_rise:  cover property ($rose(q.sync));
	c_alert_kept: cover property (!host_alert_n ##1 rd_two ##1 !host_alert_n);
	c_osc_ready:  cover property ($rose(q.osc == risr2_pkg::RISR2_OSC_READY));
	c_lbd_late:   cover property (q.lbd && !q.en_two[2] ##1 q.en_two[2] ##1 !host_alert_n);

endmodule : risr2_status

`default_nettype wire

// [tb/risr2_radio_model.sv]
// event source model of the radio datapath feeding the status block
`timescale 1ns/1ps
`default_nettype none

module risr2_radio_model (
	input  wire logic       mclk,     // system clock
	input  wire logic [7:0] evt_req,  // requested one-cycle events
	input  wire logic       rssi_req, // requested signal level
	input  wire logic       osc_req,  // requested oscillator enable
	input  wire logic [7:0] one_req,  // requested first status levels
	output logic      [7:0] evt,      // sync,done,pre,tmo,miss,wut,lbd,por
	output logic            rssi_lvl, // signal above threshold
	output logic            osc_lvl,  // xtal, tx or rx enabled
	output logic      [7:0] one_lvl   // first status levels
);
	// detectors answer one cycle after the request, like a registered datapath
	always_ff @(posedge mclk) begin
		evt      <= evt_req;
		rssi_lvl <= rssi_req;
		osc_lvl  <= osc_req;
		one_lvl  <= one_req;
	end
endmodule : risr2_radio_model

`default_nettype wire

// [tb/risr2_status_tb.sv]
// self-checking bench of the second status block
`timescale 1ns/1ps
`include "risr2_defines.svh"
`default_nettype none

module risr2_status_tb;
	logic       mclk, rst_n, reg_wr, reg_rd, host_alert_n;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, evt_req, evt, one_req, one_lvl;
	logic       rssi_req, osc_req, rssi_lvl, osc_lvl;
	int         err_total, num_checks;

	risr2_radio_model src_u (.mclk(mclk), .evt_req(evt_req), .rssi_req(rssi_req),
		.osc_req(osc_req), .one_req(one_req), .evt(evt), .rssi_lvl(rssi_lvl),
		.osc_lvl(osc_lvl), .one_lvl(one_lvl));

	risr2_status #(.OSC_SETTLE_CYC(2)) dut_u (.mclk(mclk), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .sync_found_evt(evt[7]), .packet_done_evt(evt[6]),
		.preamble_found_evt(evt[5]), .sync_timeout_evt(evt[4]),
		.preamble_miss_evt(evt[3]), .signal_above_lvl(rssi_lvl),
		.wakeup_expiry_evt(evt[2]), .battery_low_evt(evt[1]), .osc_request(osc_lvl),
		.power_up_evt(evt[0]), .status_one_live(one_lvl), .host_alert_n(host_alert_n));

	// clock, 100 ns period
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic give_verdict;
		if (err_total == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : give_verdict

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
		@(posedge mclk);
	endtask : wr

	// read strobe, then sample data in the following cycle only
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp);
		@(posedge mclk);
	endtask : rd

	task automatic alert(input logic exp);
		#1;
		chk({7'h00, host_alert_n}, {7'h00, exp});
		@(posedge mclk);
	endtask : alert

	task automatic pulse(input int i);
		evt_req[i] <= 1'b1;
		@(posedge mclk);
		evt_req <= 8'h00;
		repeat (3) @(posedge mclk);
	endtask : pulse

	// main sequence
	initial begin
		rst_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00;
		evt_req = 8'h00; rssi_req = 1'b0; osc_req = 1'b0; one_req = 8'h00;
		err_total = 0; num_checks = 0;
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		rd(`RISR2_OFF_STATUS_TWO, 8'h00);
		rd(8'h10, 8'h00);
		wr(`RISR2_OFF_ENABLE_TWO, 8'hff);
		rd(`RISR2_OFF_ENABLE_TWO, 8'hff);
		wr(`RISR2_OFF_ENABLE_TWO, 8'h08);
		// enabled wake-up: alert, read, release
		pulse(2);
		alert(1'b0);
		rd(`RISR2_OFF_STATUS_TWO, 8'h08);
		alert(1'b1);
		rd(`RISR2_OFF_STATUS_TWO, 8'h00);
		// signal level as live status, kept by reads
		rssi_req <= 1'b1;
		repeat (3) @(posedge mclk);
		rd(`RISR2_OFF_STATUS_TWO, 8'h10);
		rd(`RISR2_OFF_STATUS_TWO, 8'h10);
		alert(1'b1);
		rssi_req <= 1'b0;
		repeat (3) @(posedge mclk);
		rd(`RISR2_OFF_STATUS_TWO, 8'h00);
		// preamble, sync, packet end, timeout
		pulse(5);
		rd(`RISR2_OFF_STATUS_TWO, 8'h40);
		pulse(7);
		rd(`RISR2_OFF_STATUS_TWO, 8'h80);
		pulse(6);
		rd(`RISR2_OFF_STATUS_TWO, 8'h00);
		pulse(5);
		pulse(4);
		rd(`RISR2_OFF_STATUS_TWO, 8'h00);
		pulse(3);
		rd(`RISR2_OFF_STATUS_TWO, 8'h00);
		// preamble miss taken as an interrupt source
		wr(`RISR2_OFF_ENABLE_TWO, 8'h20);
		pulse(3);
		alert(1'b0);
		rd(`RISR2_OFF_STATUS_TWO, 8'h20);
		alert(1'b1);
		// battery low latched while disabled, interrupts once enabled
		pulse(1);
		alert(1'b1);
		rd(`RISR2_OFF_STATUS_TWO, 8'h04);
		rd(`RISR2_OFF_STATUS_TWO, 8'h04);
		wr(`RISR2_OFF_ENABLE_TWO, 8'h0c);
		alert(1'b0);
		rd(`RISR2_OFF_STATUS_TWO, 8'h04);
		alert(1'b1);
		rd(`RISR2_OFF_STATUS_TWO, 8'h00);
		// power-up flag
		wr(`RISR2_OFF_ENABLE_TWO, 8'h01);
		pulse(0);
		alert(1'b0);
		rd(`RISR2_OFF_STATUS_TWO, 8'h01);
		alert(1'b1);
		// oscillator settling and return to idle
		osc_req <= 1'b1;
		repeat (8) @(posedge mclk);
		rd(`RISR2_OFF_STATUS_TWO, 8'h02);
		osc_req <= 1'b0;
		repeat (4) @(posedge mclk);
		rd(`RISR2_OFF_STATUS_TWO, 8'h00);
		// shared line held by the first register
		wr(`RISR2_OFF_ENABLE_ONE, 8'h01);
		one_req <= 8'h01;
		wr(`RISR2_OFF_ENABLE_TWO, 8'h08);
		pulse(2);
		alert(1'b0);
		rd(`RISR2_OFF_STATUS_TWO, 8'h08);
		alert(1'b0);
		rd(`RISR2_OFF_STATUS_ONE, 8'h01);
		alert(1'b1);
		give_verdict();
	end

	// watchdog against a hung sequence
	initial begin
		repeat (3000) @(posedge mclk);
		err_total++;
		give_verdict();
	end
endmodule : risr2_status_tb

`default_nettype wire
